// ### pmc_power_ctl.sv
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module pmc_power_ctl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        resume_done,
  input  wire logic        resume_remote,
  input  wire logic        state_normal,
  input  wire logic        config_done,
  input  wire logic        phy_clk_present,
  input  wire logic        watchdog_expired,
  input  wire logic        deconfigure,
  output logic             clr_wake_status,
  output logic             clr_wakeup_source_bit1,
  output logic             clr_other_wake_en,
  output logic      [1:0]  sleep_state_sel,
  output logic             irq
);
  // ==========================================================
  // bus decode
  logic sel_ctl;
  logic sel_sts;
  logic sel_mask;
  logic unmapped;
  pmc_apb_dec u_dec (
    .paddr    (paddr),
    .sel_ctl  (sel_ctl),
    .sel_sts  (sel_sts),
    .sel_mask (sel_mask),
    .unmapped (unmapped)
  );
  logic setup;
  logic wr;
  assign setup = psel && !penable;
  assign wr    = psel && penable && pready && pwrite;

  // ==========================================================
  // control state
  logic       clr_sts_ff;
  logic       clr_en_ff;
  logic [1:0] susp_ff;
  logic       ready_ff;
  logic       clr_ws_ff;
  logic       clr_src_ff;
  logic       clr_en_o_ff;
  logic       nxt_clr_sts;
  logic       nxt_clr_en;
  logic [1:0] nxt_susp;
  logic       nxt_ready;
  logic       nxt_clr_ws;
  logic       nxt_clr_src;
  logic       nxt_clr_en_o;
  logic [2:0] int_mask_ff;
  logic [2:0] nxt_int_mask;
  logic [2:0] int_sts;
  logic [2:0] int_set;
  logic [2:0] int_clr;

  always_comb begin
    nxt_clr_sts  = clr_sts_ff;
    nxt_clr_en   = clr_en_ff;
    nxt_susp     = susp_ff;
    nxt_int_mask = int_mask_ff;
    if (wr && sel_ctl) begin
      nxt_clr_sts = pwdata[pmc_pkg::PMC_CLR_STS_BIT];
      nxt_clr_en  = pwdata[pmc_pkg::PMC_CLR_EN_BIT];
      nxt_susp    = pwdata[pmc_pkg::PMC_SUSP_LSB +: 2];
    end
    // deconfigure beats a same-cycle write so the unconfigured state stays legal
    if (deconfigure) begin
      nxt_susp = pmc_pkg::PMC_SLEEP_STATE_C;
    end
    if (wr && sel_mask) begin
      nxt_int_mask = pwdata[2:0];
    end
    // one-cycle clear strobes to the wakeup status and enable logic
    nxt_clr_ws   = resume_done && clr_sts_ff;
    nxt_clr_src  = resume_done && clr_sts_ff;
    // remote resume only; spared enables are simply not driven here
    nxt_clr_en_o = resume_done && resume_remote && clr_en_ff;
    // without phy clocks the flag waits for the watchdog
    nxt_ready    = state_normal && config_done && (phy_clk_present || watchdog_expired);
  end

  always_comb begin
    int_set = {deconfigure, nxt_ready && !ready_ff, resume_done};
    int_clr = (wr && sel_sts) ? pwdata[2:0] : 3'h0;
  end

  pmc_sticky u_sticky (
    .pclk    (pclk),
    .presetn (presetn),
    .set_i   (int_set),
    .clr_i   (int_clr),
    .sts_ff  (int_sts)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_sts_ff  <= pmc_pkg::PMC_CLR_STS_RST;
      clr_en_ff   <= pmc_pkg::PMC_CLR_EN_RST;
      susp_ff     <= pmc_pkg::PMC_SUSP_RST;
      ready_ff    <= pmc_pkg::PMC_READY_RST;
      clr_ws_ff   <= 1'h0;
      clr_src_ff  <= 1'h0;
      clr_en_o_ff <= 1'h0;
      int_mask_ff <= pmc_pkg::PMC_INT_RST;
    end else begin
      clr_sts_ff  <= nxt_clr_sts;
      clr_en_ff   <= nxt_clr_en;
      susp_ff     <= nxt_susp;
      ready_ff    <= nxt_ready;
      clr_ws_ff   <= nxt_clr_ws;
      clr_src_ff  <= nxt_clr_src;
      clr_en_o_ff <= nxt_clr_en_o;
      int_mask_ff <= nxt_int_mask;
    end
  end

  // ==========================================================
  // control and status checks
  clr_sts_wr_a : assert property (@(posedge pclk) disable iff (!presetn)
    wr && sel_ctl |=> clr_sts_ff == $past(pwdata[pmc_pkg::PMC_CLR_STS_BIT]))
    else $error("status-clear bit write lost");

  clr_en_wr_a : assert property (@(posedge pclk) disable iff (!presetn)
    wr && sel_ctl |=> clr_en_ff == $past(pwdata[pmc_pkg::PMC_CLR_EN_BIT]))
    else $error("enable-clear bit write lost");

  ctl_hold_a : assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && sel_ctl) |=> $stable(clr_sts_ff) && $stable(clr_en_ff))
    else $error("control bits changed without write");

  susp_hold_a : assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && sel_ctl) && !deconfigure |=> $stable(susp_ff))
    else $error("suspend field changed without cause");

  ready_phy_a : assert property (@(posedge pclk) disable iff (!presetn)
    state_normal && config_done && phy_clk_present |=> ready_ff)
    else $error("ready flag not set");

  ready_late_a : assert property (@(posedge pclk) disable iff (!presetn)
    state_normal && config_done && watchdog_expired |=> ready_ff)
    else $error("ready flag not set after watchdog");

  ready_low_a : assert property (@(posedge pclk) disable iff (!presetn)
    !(state_normal && config_done) |=> !ready_ff)
    else $error("ready flag set outside normal state");

  status_cause_a : assert property (@(posedge pclk) disable iff (!presetn)
    clr_wake_status |-> $past(resume_done && clr_sts_ff))
    else $error("status clear without resume");

  en_cause_a : assert property (@(posedge pclk) disable iff (!presetn)
    clr_other_wake_en |-> $past(resume_done && resume_remote && clr_en_ff))
    else $error("enable clear without remote resume");

  en_keep_a : assert property (@(posedge pclk) disable iff (!presetn)
    resume_done && !clr_en_ff |=> !clr_other_wake_en)
    else $error("enables cleared while option off");

  sts_resume_a : assert property (@(posedge pclk) disable iff (!presetn)
    resume_done |=> int_sts[0])
    else $error("resume event not latched");

  sts_reload_a : assert property (@(posedge pclk) disable iff (!presetn)
    deconfigure |=> int_sts[2])
    else $error("reload event not latched");

  // set wins, so only a clear with no new event must drop the bit
  sts_clear_a : assert property (@(posedge pclk) disable iff (!presetn)
    wr && sel_sts && pwdata[0] && !resume_done |=> !int_sts[0])
    else $error("status bit not cleared by write");

  mask_wr_a : assert property (@(posedge pclk) disable iff (!presetn)
    wr && sel_mask |=> int_mask_ff == $past(pwdata[2:0]))
    else $error("mask write lost");

  // ==========================================================
  // bus answer, outputs
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        irq_ff;
  logic [31:0] nxt_prdata;
  logic        nxt_pready;
  logic        nxt_pslverr;
  logic        nxt_irq;

  always_comb begin
    nxt_prdata  = 32'h0000_0000;
    nxt_pready  = setup;
    nxt_pslverr = setup && unmapped;
    if (setup && !pwrite) begin
      if (sel_ctl) begin
        // upper bits stay zero
        nxt_prdata[pmc_pkg::PMC_CLR_STS_BIT]   = clr_sts_ff;
        nxt_prdata[pmc_pkg::PMC_CLR_EN_BIT]    = clr_en_ff;
        nxt_prdata[pmc_pkg::PMC_READY_BIT]     = ready_ff;
        nxt_prdata[pmc_pkg::PMC_SUSP_LSB +: 2] = susp_ff;
      end else if (sel_sts) begin
        nxt_prdata[2:0] = int_sts;
      end else if (sel_mask) begin
        nxt_prdata[2:0] = int_mask_ff;
      end
    end
    nxt_irq = |(int_sts & int_mask_ff);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'h0;
      pslverr_ff <= 1'h0;
      irq_ff     <= 1'h0;
    end else begin
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      irq_ff     <= nxt_irq;
    end
  end

  // ==========================================================
  // bus and interrupt checks
  pready_pulse_a : assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready longer than one cycle");

  pready_setup_a : assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> $past(psel && !penable))
    else $error("ready without setup");

  err_ready_a : assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error outside answer");

  err_unmapped_a : assert property (@(posedge pclk) disable iff (!presetn)
    pready && $past(unmapped) |-> pslverr)
    else $error("unmapped access not flagged");

  rdata_idle_a : assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");

  rdata_ctl_a : assert property (@(posedge pclk) disable iff (!presetn)
    pready && $past(sel_ctl && !pwrite) |-> prdata[9:5] == $past({clr_sts_ff, clr_en_ff, ready_ff, susp_ff}))
    else $error("control read data wrong");

  irq_high_a : assert property (@(posedge pclk) disable iff (!presetn)
    |(int_sts & int_mask_ff) |=> irq)
    else $error("interrupt not raised");

  irq_low_a : assert property (@(posedge pclk) disable iff (!presetn)
    !(|(int_sts & int_mask_ff)) |=> !irq)
    else $error("interrupt without unmasked status");

  assign prdata                 = prdata_ff;
  assign pready                 = pready_ff;
  assign pslverr                = pslverr_ff;
  assign irq                    = irq_ff;
  assign clr_wake_status        = clr_ws_ff;
  assign clr_wakeup_source_bit1 = clr_src_ff;
  assign clr_other_wake_en      = clr_en_o_ff;
  assign sleep_state_sel        = susp_ff;

  // ==========================================================
  // checks
  clr_status_a : assert property (@(posedge pclk) disable iff (!presetn)
    resume_done && clr_sts_ff |=> clr_wake_status && clr_wakeup_source_bit1)
    else $error("status clear missed");
  keep_status_a : assert property (@(posedge pclk) disable iff (!presetn)
    !(resume_done && clr_sts_ff) |=> !clr_wake_status)
    else $error("status cleared without cause");
  src_clear_a : assert property (@(posedge pclk) disable iff (!presetn)
    clr_wakeup_source_bit1 == clr_wake_status)
    else $error("source clear mismatch");
  en_clear_a : assert property (@(posedge pclk) disable iff (!presetn)
    resume_done && resume_remote && clr_en_ff |=> clr_other_wake_en)
    else $error("enable clear missed");
  host_resume_a : assert property (@(posedge pclk) disable iff (!presetn)
    !(resume_done && resume_remote) |=> !clr_other_wake_en)
    else $error("enables cleared on host resume");
  ready_flag_a : assert property (@(posedge pclk) disable iff (!presetn)
    ready_ff |-> $past(state_normal) && $past(config_done))
    else $error("ready without normal state");
  ready_wdog_a : assert property (@(posedge pclk) disable iff (!presetn)
    !phy_clk_present && !watchdog_expired |=> !ready_ff)
    else $error("ready before watchdog");
  susp_reload_a : assert property (@(posedge pclk) disable iff (!presetn)
    deconfigure |=> sleep_state_sel == pmc_pkg::PMC_SLEEP_STATE_C)
    else $error("suspend field not reloaded");
  susp_write_a : assert property (@(posedge pclk) disable iff (!presetn)
    wr && sel_ctl && !deconfigure |=> sleep_state_sel == $past(pwdata[6:5]))
    else $error("suspend field write lost");
  upper_zero_a : assert property (@(posedge pclk) disable iff (!presetn)
    prdata[31:10] == 22'h0)
    else $error("upper bits not zero");
  sts_ready_a : assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ready_ff) |-> int_sts[1])
    else $error("ready rise not latched");
endmodule : pmc_power_ctl

// ### pmc_pkg.sv
// Behaviour
// - resume with status-clear clears four wake flags
// - same resume also clears wakeup source bit one
// - status-clear zero keeps flags; resets zero, read/write
// - enable-clear set clears enables after remote resume
// - host-initiated resume never clears wakeup enables
// - unicast, perfect, frame, magic, broadcast enables spared
// - ready flag: normal state and configuration done
// - ready held low until watchdog if no clocks
// - two-bit suspend select field, default binary 10
// - deconfigure to unconfigured reloads suspend field 10
package pmc_pkg;
  // ==========================================================
  // register map
  localparam logic [11:0] PMC_PWR_CTL_OFF  = 12'h020;
  localparam logic [11:0] PMC_INT_STS_OFF  = 12'h024;
  localparam logic [11:0] PMC_INT_MASK_OFF = 12'h028;
  // ==========================================================
  // field positions
  localparam int PMC_CLR_STS_BIT = 9;
  localparam int PMC_CLR_EN_BIT  = 8;
  localparam int PMC_READY_BIT   = 7;
  localparam int PMC_SUSP_LSB    = 5;
  localparam int PMC_WAKEUP_SOURCE_FIELD_BIT1   = 1;
  // ==========================================================
  // reset values
  localparam logic       PMC_CLR_STS_RST = 1'h0;
  localparam logic       PMC_CLR_EN_RST  = 1'h1;
  localparam logic       PMC_READY_RST   = 1'h0;
  localparam logic [1:0] PMC_SUSP_RST    = 2'h2;
  localparam logic [2:0] PMC_INT_RST     = 3'h0;
  // interrupt bits: 0 resume done, 1 ready rose, 2 reload
  typedef enum logic [1:0] {
    PMC_SLEEP_STATE_A = 2'b00,
    PMC_SLEEP_STATE_B = 2'b01,
    PMC_SLEEP_STATE_C = 2'b10,
    PMC_SLEEP_STATE_D = 2'b11
  } pmc_sleep_e;
endpackage : pmc_pkg

// ### pmc_sticky.sv
`timescale 1ns/1ps
module pmc_sticky (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] set_i,
  input  wire logic [2:0] clr_i,
  output logic      [2:0] sts_ff
);
  logic [2:0] nxt_sts;
  // set wins over a same-cycle clear
  always_comb begin
    nxt_sts = (sts_ff & ~clr_i) | set_i;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_ff <= pmc_pkg::PMC_INT_RST;
    end else begin
      sts_ff <= nxt_sts;
    end
  end
endmodule : pmc_sticky

// ### pmc_apb_dec.sv
`timescale 1ns/1ps
module pmc_apb_dec (
  input  wire logic [11:0] paddr,
  output logic             sel_ctl,
  output logic             sel_sts,
  output logic             sel_mask,
  output logic             unmapped
);
  always_comb begin
    sel_ctl  = (paddr == pmc_pkg::PMC_PWR_CTL_OFF);
    sel_sts  = (paddr == pmc_pkg::PMC_INT_STS_OFF);
    sel_mask = (paddr == pmc_pkg::PMC_INT_MASK_OFF);
    unmapped = !(sel_ctl || sel_sts || sel_mask);
  end
endmodule : pmc_apb_dec

// ### power_mgmt_control_reg_test.sv
`timescale 1ns/1ps
module power_mgmt_control_reg_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        rdone, rremote, snorm, cdone, phy, wdog, deconf, cs, cb, ce, ia;
  logic [1:0]  sel;
  int          errors, cmp_count;
  pmc_power_ctl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .resume_done(rdone), .resume_remote(rremote), .state_normal(snorm), .config_done(cdone),
    .phy_clk_present(phy), .watchdog_expired(wdog), .deconfigure(deconf), .clr_wake_status(cs),
    .clr_wakeup_source_bit1(cb), .clr_other_wake_en(ce), .sleep_state_sel(sel), .irq(irq));
  // ==========================================
  // clock, reset, watchdog
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    #200000;
    errors++;
    end_sim();
  end
  task automatic end_sim();
    if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // ==========================================
  // apb master
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) chk(32'h0, 32'h1);
    q  = prdata;
    ia = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd_chk
  // resume pulse; strobes land one cycle later
  task automatic resume(input logic remote, input logic [2:0] exp);
    @(posedge pclk);
    rdone   <= 1'b1;
    rremote <= remote;
    @(posedge pclk);
    rdone   <= 1'b0;
    @(negedge pclk);
    chk({29'h0, cs, cb, ce}, {29'h0, exp});
  endtask : resume
  // ==========================================
  // scenarios
  task automatic t_fields();
    int i;
    rd_chk(12'h020, 32'h0000_0140);
    chk({30'h0, sel}, 32'h2);
    apb(1'b1, 12'h020, 32'hFFFF_FFFF);
    rd_chk(12'h020, 32'h0000_0360);
    for (i = 0; i < 4; i++) begin
      apb(1'b1, 12'h020, i << 5);
      rd_chk(12'h020, i << 5);
      chk({30'h0, sel}, i);
    end
  endtask : t_fields
  task automatic t_resume();
    resume(1'b1, 3'h0);
    apb(1'b1, 12'h020, 32'h0000_0300);
    resume(1'b0, 3'h6);
    resume(1'b1, 3'h7);
    @(posedge pclk);
    deconf <= 1'b1;
    @(posedge pclk);
    deconf <= 1'b0;
    repeat (2) @(negedge pclk);
    chk({30'h0, sel}, 32'h2);
    rd_chk(12'h020, 32'h0000_0340);
  endtask : t_resume
  task automatic t_ready();
    snorm <= 1'b1;
    cdone <= 1'b1;
    phy   <= 1'b1;
    rd_chk(12'h020, 32'h0000_03C0);
    phy   <= 1'b0;
    rd_chk(12'h020, 32'h0000_0340);
    wdog  <= 1'b1;
    rd_chk(12'h020, 32'h0000_03C0);
    cdone <= 1'b0;
    rd_chk(12'h020, 32'h0000_0340);
  endtask : t_ready
  task automatic t_irq();
    logic a;
    apb(1'b1, 12'h024, 32'h7);
    rd_chk(12'h024, 32'h0);
    resume(1'b0, 3'h6);
    rd_chk(12'h024, 32'h1);
    apb(1'b1, 12'h028, 32'h0);
    repeat (2) @(negedge pclk);
    a = irq;
    apb(1'b1, 12'h028, 32'h7);
    rd_chk(12'h028, 32'h7);
    chk({31'h0, a ^ irq}, 32'h1);
    apb(1'b1, 12'h024, 32'h1);
    repeat (2) @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    rd_chk(12'h024, 32'h0);
    cdone <= 1'b1;
    rd_chk(12'h024, 32'h2);
    @(posedge pclk);
    deconf <= 1'b1;
    @(posedge pclk);
    deconf <= 1'b0;
    rd_chk(12'h024, 32'h6);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 12'h028, 32'h0);
    repeat (2) @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    rd_chk(12'h030, 32'h0);
    chk({31'h0, ia}, 32'h1);
  endtask : t_irq
  initial begin
    {psel, penable, pwrite, rdone, rremote, snorm, cdone, phy, wdog, deconf} = '0;
    paddr     = 12'h000;
    pwdata    = 32'h0;
    errors    = 0;
    cmp_count = 0;
    presetn   = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_fields();
    t_resume();
    t_ready();
    t_irq();
    end_sim();
  end
endmodule : power_mgmt_control_reg_test
